// >>> common/sfcr_defines.vh
`ifndef SFCR_DEFINES_VH
`define SFCR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// opcodes of the continuous array reads
`define SFCR_OPC_LEGACY 8'hE8
`define SFCR_OPC_FAST 8'h1B

////////////////////////////////////////////////////////////////////////////
// dummy bytes clocked in after the three address bytes
`define SFCR_DUMMY_LEGACY 3'h4
`define SFCR_DUMMY_FAST 3'h2
`define SFCR_DUMMY_BUF 3'h1

////////////////////////////////////////////////////////////////////////////
// framing of the command header
`define SFCR_BITS_PER_BYTE 3'h7
`define SFCR_ADDR_BYTES 3'h3

////////////////////////////////////////////////////////////////////////////
// last byte position of a page or buffer
`define SFCR_STD_LAST_BYTE 9'h107
`define SFCR_BIN_LAST_BYTE 9'h0FF

////////////////////////////////////////////////////////////////////////////
// field positions inside the 24-bit address word
`define SFCR_STD_PAGE_MSB 20
`define SFCR_STD_PAGE_LSB 9
`define SFCR_STD_BYTE_MSB 8
`define SFCR_BIN_PAGE_MSB 19
`define SFCR_BIN_PAGE_LSB 8
`define SFCR_BIN_BYTE_MSB 7

////////////////////////////////////////////////////////////////////////////
// data source select on the memory port
`define SFCR_SRC_ARRAY 2'h0
`define SFCR_SRC_BUF1 2'h1
`define SFCR_SRC_BUF2 2'h2

////////////////////////////////////////////////////////////////////////////
// reset values of the pin synchronisers {rst_n, bin, cs_n, sck, si}
`define SFCR_SYNC_RST 5'h14

`endif

// >>> rtl/sfcr_sync.v
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for a group of unrelated pin levels
module sfcr_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_sys_i, // system clock
    input wire rst_i, // synchronous reset, active high
    input wire [WIDTH-1:0] async_i, // levels from outside the domain
    output reg [WIDTH-1:0] sync_o // levels safe to read
);

    reg [WIDTH-1:0] meta_r; // first stage, read only by sync_o

    // first stage may go metastable; only the second stage reads it
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule // sfcr_sync

`default_nettype wire

// >>> rtl/sfcr_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_defines.vh"

// Notes on behaviour
// - falling chip select, then opcode, then address
// - all serial fields travel msb first
// - three address bytes, real bits plus padding
// - padding depends on command and page size
// - standard page buffer index is nine bits
// - standard array: twelve page, nine byte bits
// - binary page: eight buffer, twenty array bits
// - opcode picks array or either buffer
// - works with spi mode 0 and 3
// - legacy read: E8h, address, four dummies
// - address counter advances on its own
// - page end rolls to next page seamlessly
// - array end wraps to first page
// - select rising ends read, output floats
// - array read bypasses buffers, leaves them intact
// - fast read: 1Bh, address, two dummies
// - sample input on rising clock, selected only
// - change output on falling clock edge
// - output floats while deselected
// - reset pin low aborts and holds idle
module sfcr_top #(
    parameter [7:0] BUF1_READ_OPC = 8'hD4, // buffer 1 read opcode
    parameter [7:0] BUF2_READ_OPC = 8'hD6, // buffer 2 read opcode
    parameter [2:0] BUF_DUMMY = `SFCR_DUMMY_BUF // buffer read dummies
) (
    input wire clk_sys_i, // system clock, 100 MHz
    input wire rst_i, // synchronous reset, active high
    input wire spi_sck_i, // serial clock pin
    input wire spi_cs_n_i, // chip select pin, active low
    input wire spi_si_i, // serial data in pin
    input wire flash_rst_n_i, // device reset pin, active low
    input wire page_bin_i, // page size strap, 1 = binary
    input wire [7:0] mem_data_i, // byte from the memory port
    output reg spi_so_o, // serial data out
    output reg spi_so_oe_o, // serial out enable, high drives
    output reg mem_rd_o, // one-cycle fetch strobe
    output reg [1:0] mem_src_o, // array or buffer select
    output reg [11:0] mem_page_o, // page of the fetch
    output reg [8:0] mem_byte_o, // byte of the fetch
    output reg busy_o, // command in progress
    output reg page_bin_o // stored page size
);

    ////////////////////////////////////////////////////////////////////////
    // states of the command sequencer
    localparam [2:0] ST_IDLE = 3'h0; // wait for select falling
    localparam [2:0] ST_OPC = 3'h1; // shifting the opcode
    localparam [2:0] ST_ADDR = 3'h2; // shifting address bytes
    localparam [2:0] ST_DUMMY = 3'h3; // counting dummy bytes
    localparam [2:0] ST_DATA = 3'h4; // streaming bytes out
    localparam [2:0] ST_SKIP = 3'h5; // unknown opcode, wait deselect

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    wire [4:0] pins_s; // synchronised pin levels
    wire si_s; // serial input level
    wire sck_s; // serial clock level
    wire cs_n_s; // chip select level, active low
    wire bin_s; // page size strap level
    wire pin_rst_n_s; // reset pin level, active low
    reg sck_d_r; // serial clock one cycle ago
    reg cs_n_d_r; // chip select one cycle ago
    wire sck_rise; // serial clock rising edge
    wire sck_fall; // serial clock falling edge
    wire cs_fall; // chip select falling edge
    wire dev_rst; // combined device reset

    sfcr_sync #(
        .WIDTH(5),
        .RST_VAL(`SFCR_SYNC_RST)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({flash_rst_n_i, page_bin_i, spi_cs_n_i, spi_sck_i,
                  spi_si_i}),
        .sync_o(pins_s)
    );

    assign si_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign cs_n_s = pins_s[2];
    assign bin_s = pins_s[3];
    assign pin_rst_n_s = pins_s[4];

    // both polarities work since the edges, not the idle level, count
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign cs_fall = ~cs_n_s & cs_n_d_r;
    assign dev_rst = rst_i | ~pin_rst_n_s;

    // previous levels for the edge detectors
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sck_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stored page size, taken from the strap while reset is held
    // a strap change during operation is ignored to keep addressing stable
    always @(posedge clk_sys_i) begin
        if (dev_rst) begin
            page_bin_o <= bin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer registers
    reg [2:0] state_r; // sequencer state
    reg [2:0] bit_cnt_r; // bit within current header byte
    reg [2:0] byte_cnt_r; // byte within current header field
    reg [2:0] dum_bytes_r; // dummy bytes expected
    reg [7:0] opc_sh_r; // opcode shift register
    reg [23:0] addr_sh_r; // address shift register
    reg [2:0] out_cnt_r; // bit within output byte, 0 reloads
    reg [7:0] out_sh_r; // output shift register
    reg [7:0] next_byte_r; // prefetched byte
    reg rd_pend_r; // fetch answer due this cycle
    reg [1:0] src_r; // source chosen by the opcode

    wire [7:0] opc_full; // opcode including the current bit
    wire [23:0] addr_full; // address including the current bit
    wire [8:0] last_byte; // last byte of a page or buffer

    assign opc_full = {opc_sh_r[6:0], si_s};
    assign addr_full = {addr_sh_r[22:0], si_s};
    assign last_byte = page_bin_o ? `SFCR_BIN_LAST_BYTE
                                  : `SFCR_STD_LAST_BYTE;

    ////////////////////////////////////////////////////////////////////////
    // next fetch address; buffers wrap in place, array crosses pages
    reg [11:0] page_nxt; // page after the current byte
    reg [8:0] byte_nxt; // byte after the current byte

    always @* begin
        page_nxt = mem_page_o;
        byte_nxt = mem_byte_o + 9'h001;
        if (mem_byte_o >= last_byte) begin
            byte_nxt = 9'h000;
            if (src_r == `SFCR_SRC_ARRAY) begin
                // 12-bit page rolls over from the last page to page 0
                page_nxt = mem_page_o + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start address split by page size and by source
    reg [11:0] page_start; // decoded start page
    reg [8:0] byte_start; // decoded start byte

    always @* begin
        page_start = 12'h000;
        byte_start = 9'h000;
        if (src_r == `SFCR_SRC_ARRAY) begin
            if (page_bin_o) begin
                // twelve page bits over eight byte bits
                page_start = addr_full[`SFCR_BIN_PAGE_MSB:
                                       `SFCR_BIN_PAGE_LSB];
                byte_start = {1'b0,
                    addr_full[`SFCR_BIN_BYTE_MSB:0]};
            end else begin
                // twelve page bits over nine byte bits
                page_start = addr_full[`SFCR_STD_PAGE_MSB:
                                       `SFCR_STD_PAGE_LSB];
                byte_start = addr_full[`SFCR_STD_BYTE_MSB:0];
            end
        end else begin
            // buffer index only, upper bits are padding
            if (page_bin_o) begin
                byte_start = {1'b0,
                    addr_full[`SFCR_BIN_BYTE_MSB:0]};
            end else begin
                byte_start = addr_full[`SFCR_STD_BYTE_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch answer capture; memory answers in the cycle after the strobe
    always @(posedge clk_sys_i) begin
        if (dev_rst) begin
            rd_pend_r <= 1'b0;
            next_byte_r <= 8'h00;
        end else begin
            rd_pend_r <= mem_rd_o;
            if (rd_pend_r) begin
                next_byte_r <= mem_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always @(posedge clk_sys_i) begin
        if (dev_rst) begin
            // abort whatever runs and stay idle while held
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
            dum_bytes_r <= 3'h0;
            opc_sh_r <= 8'h00;
            addr_sh_r <= 24'h000000;
            out_cnt_r <= 3'h0;
            out_sh_r <= 8'h00;
            src_r <= `SFCR_SRC_ARRAY;
            spi_so_o <= 1'b0;
            spi_so_oe_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_src_o <= `SFCR_SRC_ARRAY;
            mem_page_o <= 12'h000;
            mem_byte_o <= 9'h000;
            busy_o <= 1'b0;
        end else begin
            mem_rd_o <= 1'b0;
            if (cs_n_s) begin
                // deselected: end at once and float the output
                state_r <= ST_IDLE;
                spi_so_oe_o <= 1'b0;
                busy_o <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        // only a fresh select edge opens a command
                        if (cs_fall) begin
                            state_r <= ST_OPC;
                            bit_cnt_r <= 3'h0;
                            byte_cnt_r <= 3'h0;
                            busy_o <= 1'b1;
                        end
                    end
                    ST_OPC: begin
                        if (sck_rise) begin
                            opc_sh_r <= opc_full;
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == `SFCR_BITS_PER_BYTE) begin
                                state_r <= ST_ADDR;
                                byte_cnt_r <= 3'h0;
                                if (opc_full == `SFCR_OPC_LEGACY) begin
                                    src_r <= `SFCR_SRC_ARRAY;
                                    dum_bytes_r <= `SFCR_DUMMY_LEGACY;
                                end else if (opc_full == `SFCR_OPC_FAST)
                                begin
                                    // same count in both page sizes
                                    src_r <= `SFCR_SRC_ARRAY;
                                    dum_bytes_r <= `SFCR_DUMMY_FAST;
                                end else if (opc_full == BUF1_READ_OPC)
                                begin
                                    src_r <= `SFCR_SRC_BUF1;
                                    dum_bytes_r <= BUF_DUMMY;
                                end else if (opc_full == BUF2_READ_OPC)
                                begin
                                    src_r <= `SFCR_SRC_BUF2;
                                    dum_bytes_r <= BUF_DUMMY;
                                end else begin
                                    // unsupported command: stay silent
                                    state_r <= ST_SKIP;
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (sck_rise) begin
                            addr_sh_r <= addr_full;
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == `SFCR_BITS_PER_BYTE) begin
                                byte_cnt_r <= byte_cnt_r + 3'h1;
                                if (byte_cnt_r ==
                                    `SFCR_ADDR_BYTES - 3'h1) begin
                                    // prefetch the first byte early
                                    state_r <= ST_DUMMY;
                                    byte_cnt_r <= 3'h0;
                                    mem_src_o <= src_r;
                                    mem_page_o <= page_start;
                                    mem_byte_o <= byte_start;
                                    mem_rd_o <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // dummy values are don't care, only counted
                        if (sck_rise) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == `SFCR_BITS_PER_BYTE) begin
                                byte_cnt_r <= byte_cnt_r + 3'h1;
                                if (byte_cnt_r == dum_bytes_r - 3'h1)
                                begin
                                    state_r <= ST_DATA;
                                    out_cnt_r <= 3'h0;
                                end
                            end
                        end
                    end
                    ST_DATA: begin
                        // input is ignored; stream runs until deselect
                        if (sck_fall) begin
                            spi_so_oe_o <= 1'b1;
                            out_cnt_r <= out_cnt_r + 3'h1;
                            if (out_cnt_r == 3'h0) begin
                                // reload and fetch ahead, no gap
                                spi_so_o <= next_byte_r[7];
                                out_sh_r <= {next_byte_r[6:0], 1'b0};
                                mem_page_o <= page_nxt;
                                mem_byte_o <= byte_nxt;
                                mem_rd_o <= 1'b1;
                            end else begin
                                spi_so_o <= out_sh_r[7];
                                out_sh_r <= {out_sh_r[6:0], 1'b0};
                            end
                        end
                    end
                    ST_SKIP: begin
                        // wait here until chip select returns high
                        spi_so_oe_o <= 1'b0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // sfcr_top

`default_nettype wire

// >>> tb/sfcr_host.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////
// spi host: frames a command, keeps the received data bytes
module sfcr_host (
    input wire logic so_i, // serial data seen on the wire
    output logic sck_o, // serial clock, runs only inside frames
    output logic cs_n_o, // chip select, active low
    output logic si_o // serial data to the device
);
    localparam realtime HALF = 62.5; // half of a 125 ns link clock
    logic [7:0] rx_q[$]; // data bytes of the last frame

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // one byte out and one in; si moves while sck is low
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin // msb first
            sck_o = 1'b0;
            si_o = tx[i];
            #HALF sck_o = 1'b1;
            rx[i] = so_i;
            #HALF;
        end
    endtask

    // select, opcode, three address bytes, dummies, then data
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
        input int nd, input int nb, input bit m3);
        logic [7:0] b;
        rx_q.delete();
        sck_o = m3; // idle level picks mode 0 or 3
        #HALF cs_n_o = 1'b0;
        #HALF shift(opc, b);
        for (int i = 2; i >= 0; i--) begin
            shift(adr[8*i +: 8], b);
        end
        repeat (nd) shift(8'hA5, b); // dummy count
        repeat (nb) begin
            shift(8'hFF, b);
            rx_q.push_back(b);
        end
        if (!m3) sck_o = 1'b0;
        #HALF cs_n_o = 1'b1; // select held low to here
        si_o = ~si_o; // released line shows no stale level
        #HALF;
    endtask
endmodule // sfcr_host

`default_nettype wire

// >>> tb/sfcr_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_defines.vh"

////////////////////////////////////////
// port-level rules of the continuous read sequencer
module sfcr_properties (
    input wire logic clk_sys_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic spi_sck_i, // serial clock pin
    input wire logic spi_cs_n_i, // chip select pin
    input wire logic flash_rst_n_i, // device reset pin
    input wire logic spi_so_o, // serial data out
    input wire logic spi_so_oe_o, // serial out enable
    input wire logic mem_rd_o, // fetch strobe
    input wire logic [1:0] mem_src_o, // fetch source
    input wire logic [11:0] mem_page_o, // fetch page
    input wire logic [8:0] mem_byte_o, // fetch byte
    input wire logic busy_o, // command in progress
    input wire logic page_bin_o // stored page size
);
    default clocking cb @(posedge clk_sys_i); endclocking
    // the reset pin clears the sequencer two cycles late; skip that window
    default disable iff (rst_i || !flash_rst_n_i);

    logic seen_r; // a fetch already happened in this command
    logic [11:0] pg_r; // page of the previous fetch
    logic [8:0] by_r; // byte of the previous fetch
    wire [8:0] last_w = page_bin_o ? `SFCR_BIN_LAST_BYTE :
        `SFCR_STD_LAST_BYTE;
    wire wrap_w = by_r >= last_w; // bytes past the end roll too
    wire [8:0] nby_w = wrap_w ? 9'h000 : by_r + 9'h001;
    wire [11:0] npg_w = (wrap_w && mem_src_o == `SFCR_SRC_ARRAY) ?
        pg_r + 12'h001 : pg_r; // page 4095 wraps to 0 by width

    // remember the last fetch address within one command
    always @(posedge clk_sys_i) begin
        if (rst_i || !busy_o) seen_r <= 1'b0;
        else if (mem_rd_o) seen_r <= 1'b1;
        if (mem_rd_o) begin
            pg_r <= mem_page_o;
            by_r <= mem_byte_o;
        end
    end

    ////////////////////////////////////////
    AST_ADVANCE: assert property (mem_rd_o && seen_r |->
        mem_byte_o == nby_w && mem_page_o == npg_w)
        else $error("fetch address did not step");
    AST_ADDR_HOLD: assert property (seen_r && !mem_rd_o |->
        $stable(mem_page_o) && $stable(mem_byte_o))
        else $error("fetch address moved without strobe");
    AST_FETCH_PULSE: assert property (mem_rd_o |=> !mem_rd_o [*8])
        else $error("fetch strobes too close");
    AST_NO_IDLE_FETCH: assert property (!busy_o |-> !mem_rd_o)
        else $error("fetch outside a command");
    AST_FIRST_BIT: assert property ($rose(spi_so_oe_o) |-> mem_rd_o)
        else $error("output started without next fetch");
    AST_SO_ON_FALL: assert property (spi_so_oe_o && $past(spi_so_oe_o) &&
        $changed(spi_so_o) |-> !$past(spi_sck_i, 2))
        else $error("output changed away from a clock fall");
    AST_END_ON_DESEL: assert property ($rose(spi_cs_n_i) |->
        ##[1:5] (!busy_o && !spi_so_oe_o))
        else $error("read not ended by deselect");
    AST_FLOAT_DESEL: assert property (spi_cs_n_i [*5] |->
        !spi_so_oe_o)
        else $error("output driven while deselected");
    AST_STRAP_HOLD: assert property (flash_rst_n_i [*6] |->
        $stable(page_bin_o))
        else $error("page size changed outside reset");
endmodule // sfcr_properties

bind sfcr_top sfcr_properties i_props (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .spi_sck_i(spi_sck_i),
    .spi_cs_n_i(spi_cs_n_i),
    .flash_rst_n_i(flash_rst_n_i),
    .spi_so_o(spi_so_o),
    .spi_so_oe_o(spi_so_oe_o),
    .mem_rd_o(mem_rd_o),
    .mem_src_o(mem_src_o),
    .mem_page_o(mem_page_o),
    .mem_byte_o(mem_byte_o),
    .busy_o(busy_o),
    .page_bin_o(page_bin_o)
);

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_defines.vh"

module tb;
    logic clk_sys_i, rst_i, flash_rst_n_i, page_bin_i;
    logic [7:0] mem_data_i; // memory port model output
    wire sck, cs_n, si, so, so_oe, mem_rd, busy, bin;
    wire [1:0] src;
    wire [11:0] pg;
    wire [8:0] by;
    wire so_w = so_oe ? so : ~so; // undriven wire shows no stale bit
    int mismatches = 0;
    int num_checks = 0;
    int rd_cnt; // fetch strobes in a frame
    bit oe_seen; // output enable seen in a frame

    sfcr_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_si_i(si),
        .flash_rst_n_i(flash_rst_n_i), .page_bin_i(page_bin_i),
        .mem_data_i(mem_data_i), .spi_so_o(so), .spi_so_oe_o(so_oe),
        .mem_rd_o(mem_rd), .mem_src_o(src), .mem_page_o(pg),
        .mem_byte_o(by), .busy_o(busy), .page_bin_o(bin));
    sfcr_host i_host (.so_i(so_w), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////
    // memory content: each location names its own source and address
    function automatic logic [7:0] data_of(logic [1:0] s, logic [11:0] p,
        logic [8:0] b);
        return b[7:0] ^ p[7:0] ^ {p[11:8], b[8], s, 1'b0};
    endfunction

    // memory answers on the falling clock edge while the strobe is still high
    always @(negedge clk_sys_i) begin
        if (mem_rd === 1'b1) mem_data_i <= data_of(src, pg, by);
    end
    always @(posedge clk_sys_i) begin
        if (mem_rd === 1'b1) rd_cnt++;
        if (so_oe === 1'b1) oe_seen = 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // one read frame; expected bytes walk the address by the page rules
    task automatic t_read(input logic [7:0] opc, input logic [1:0] s,
        input logic [11:0] p, input logic [8:0] b, input int nd,
        input int nb, input bit m3);
        logic [8:0] last;
        logic [23:0] adr;
        last = page_bin_i ? 9'h0FF : 9'h107;
        adr = (s != 2'h0) ? {15'h0, b} :
            page_bin_i ? {4'h0, p, b[7:0]} : {3'h0, p, b};
        i_host.frame(opc, adr, nd, nb, m3);
        foreach (i_host.rx_q[k]) begin
            check(i_host.rx_q[k], data_of(s, p, b));
            if (b >= last) begin
                b = 9'h000;
                if (s == 2'h0) p = p + 12'h001;
            end
            else b = b + 9'h001;
        end
        repeat (6) @(negedge clk_sys_i);
        check(busy, 1'b0);
        check(so_oe, 1'b0);
    endtask

    // unknown opcode: no fetch and no output
    task automatic t_refuse();
        rd_cnt = 0;
        oe_seen = 1'b0;
        i_host.frame(8'h03, 24'h000010, 1, 2, 1'b0);
        check(rd_cnt, 0);
        check(oe_seen, 1'b0);
    endtask

    // reset pin pulled low in mid-stream aborts the read
    task automatic t_abort();
        fork
            i_host.frame(`SFCR_OPC_FAST, 24'h000100, 2, 3, 1'b0);
            begin
                #7us;
                check(so_oe, 1'b1);
                @(negedge clk_sys_i) flash_rst_n_i = 1'b0;
                repeat (4) @(negedge clk_sys_i);
                check(busy, 1'b0);
                check(so_oe, 1'b0);
                flash_rst_n_i = 1'b1;
            end
        join
        repeat (4) @(negedge clk_sys_i);
    endtask

    // strap re-latched by the reset pin, binary page reads
    task automatic t_bin();
        page_bin_i = 1'b1;
        flash_rst_n_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        flash_rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check(bin, 1'b1);
        t_read(`SFCR_OPC_FAST, 2'h0, 12'h007, 9'h0FE, 2, 3, 1'b0);
        t_read(`SFCR_OPC_LEGACY, 2'h0, 12'hFFF, 9'h0FF, 4, 2, 1'b1);
        t_read(8'hD6, 2'h2, 12'h000, 9'h0FF, 1, 2, 1'b0);
        page_bin_i = 1'b0;
    endtask

    ////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        flash_rst_n_i = 1'b1;
        page_bin_i = 1'b0;
        mem_data_i = 8'h00;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check(bin, 1'b0);
        check({busy, so_oe, mem_rd}, 3'h0);
        t_read(`SFCR_OPC_LEGACY, 2'h0, 12'h005, 9'h105, 4, 5, 1'b0);
        t_read(`SFCR_OPC_FAST, 2'h0, 12'hFFF, 9'h106, 2, 4, 1'b1);
        t_read(8'hD4, 2'h1, 12'h000, 9'h106, 1, 3, 1'b0);
        t_refuse();
        t_abort();
        t_read(`SFCR_OPC_LEGACY, 2'h0, 12'h800, 9'h1FF, 4, 2, 1'b1);
        t_bin();
        wrap_up();
    end

    // cut a hang well past the expected 86 us run
    initial begin
        #400us;
        mismatches++;
        wrap_up();
    end
endmodule // tb

`default_nettype wire
